//--- panel_pkg.sv
// Shared constants, enumerations and carrier types of the operator panel control logic.
package panel_pkg;

  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned LAMP_TEST_MS = 3000;
  localparam int unsigned LAMP_TEST_CYC = LAMP_TEST_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_HOLD_MS = 2000;
  localparam int unsigned LOCK_HOLD_CYC = LOCK_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned REPEAT_DELAY_MS = 500;
  localparam int unsigned REPEAT_DELAY_CYC = REPEAT_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned REPEAT_RATE_MS = 100;
  localparam int unsigned REPEAT_RATE_CYC = REPEAT_RATE_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned MSG_MS = 1500;
  localparam int unsigned MSG_CYC = MSG_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W = 32;

  // ==========================================================================
  // Menu numbers.
  localparam logic [9:0] MENU_FIRST = 10'h001;
  localparam logic [9:0] MENU_BASIC_LAST = 10'h007;
  localparam logic [9:0] MENU_VIEW_LAST = 10'h0FF;
  localparam logic [9:0] MENU_ALL_LAST = 10'h3E7;
  localparam logic [9:0] MENU_LOCK_STATUS = 10'h0DD;

  // ==========================================================================
  // Control modes and parameter-set source.
  localparam logic [1:0] MODE_KEYBOARD = 2'h1;
  localparam logic [1:0] MODE_REMOTE = 2'h2;
  localparam logic [1:0] MODE_SERIAL = 2'h3;
  localparam logic [2:0] PSET_EXTERNAL = 3'h0;
  localparam logic [2:0] PSET_MAX = 3'h4;

  // ==========================================================================
  // Display message selector.
  typedef enum logic [2:0] {
    SHOW_LAMP_TEST = 3'b000,
    SHOW_MENU = 3'b001,
    SHOW_LOCKED = 3'b010,
    SHOW_UNLOCKED = 3'b011
  } show_t;

  typedef struct packed {
    logic next;
    logic prev;
    logic plus;
    logic minus;
    logic enter;
    logic start_stop;
    logic jog_rev;
    logic jog_fwd;
  } keys_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic jog_rev;
    logic jog_fwd;
    logic alarm_reset;
  } cmd_t;

  typedef struct packed {
    logic [1:0] control_mode;
    logic [2:0] pset_select;
    logic extended_access;
    logic all_menus;
    logic jog_rev_enable;
    logic jog_fwd_enable;
  } config_t;

  // Saturating cycle timer step, shared by every timer of the block.
  function automatic logic [TIMER_W-1:0] tick(input logic [TIMER_W-1:0] t);
    tick = (t == '1) ? t : t + 1'b1;
  endfunction

endpackage

//--- panel_key_edge.sv
// Rising-edge detector with hold-to-repeat for the navigation keys.
`timescale 1ns/1ps
`default_nettype none
module panel_key_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key,
  output logic press
);
  logic key_q, key_d;
  logic [panel_pkg::TIMER_W-1:0] hold_q, hold_d;
  logic press_q, press_d;

  // ==========================================================================
  // Holding the key emits a first pulse, then repeats after a delay.
  always_comb begin
    key_d = key;
    press_d = 1'b0;
    hold_d = '0;
    if (key && !key_q) begin
      press_d = 1'b1;
    end else if (key) begin
      hold_d = panel_pkg::tick(hold_q);
      if (hold_q == panel_pkg::TIMER_W'(panel_pkg::REPEAT_DELAY_CYC)) begin
        press_d = 1'b1;
        hold_d = panel_pkg::TIMER_W'(panel_pkg::REPEAT_DELAY_CYC - panel_pkg::REPEAT_RATE_CYC);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= 1'b0;
      hold_q <= '0;
      press_q <= 1'b0;
    end else begin
      key_q <= key_d;
      hold_q <= hold_d;
      press_q <= press_d;
    end
  end

  assign press = press_q;
endmodule // panel_key_edge
`default_nettype wire

//--- panel_value_edit.sv
// Value editor: pending value that flashes until committed.
`timescale 1ns/1ps
`default_nettype none
module panel_value_edit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic dec,
  input wire logic commit,
  input wire logic abandon,
  input wire logic [15:0] stored,
  output logic [15:0] value,
  output logic pending,
  output logic write
);
  logic [15:0] value_q, value_d;
  logic pending_q, pending_d;
  logic write_q, write_d;

  // ==========================================================================
  // Editing starts from the stored value; leaving the menu discards it.
  always_comb begin
    value_d = pending_q ? value_q : stored;
    pending_d = pending_q;
    write_d = 1'b0;
    if (abandon) begin
      pending_d = 1'b0;
    end else if (inc) begin
      value_d = value_d + 16'h0001;
      pending_d = 1'b1;
    end else if (dec) begin
      value_d = value_d - 16'h0001;
      pending_d = 1'b1;
    end else if (commit && pending_q) begin
      pending_d = 1'b0;
      write_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= 16'h0000;
      pending_q <= 1'b0;
      write_q <= 1'b0;
    end else begin
      value_q <= value_d;
      pending_q <= pending_d;
      write_q <= write_d;
    end
  end

  assign value = value_q;
  assign pending = pending_q;
  assign write = write_q;
endmodule // panel_value_edit
`default_nettype wire

//--- operator_panel.sv
// Operator panel control: display sequencing, menus, editing, lock and command routing.
// Function
// - At power-up light all segments a few seconds, then show menu 001.
// - A start command from the source picked by control mode (keys, serial or remote) lights the start/stop LED.
// - An accepted stop command turns the start/stop LED off.
// - Running LED flashes while ramping, stays lit at full voltage.
// - Menu 007 off limits navigation to menus 001 to 007.
// - Menu 007 on, 008 off also reaches viewing menus and alarm lists.
// - Next and previous step one menu; holding them scrolls continuously.
// - Plus and minus change the edited value, which flashes until confirmed.
// - Enter commits the value to steady display and also resets alarms.
// - Start/stop key only starts and stops the motor.
// - Jog keys command reverse and forward jog only when enabled.
// - Next plus enter held 2 s locks the keypad and shows locked.
// - Same combination held 2 s while locked unlocks and shows unlocked.
// - Locked keypad allows viewing but rejects edits and motor keys.
// - A rejected edit or motor key while locked shows the locked message.
// - Lock state reads as menu 221, no or YES, default no.
// - Control mode picks command source; unlocked keypad may reset alarms remotely.
// - Parameter set from external inputs when 0, else internal 1 to 4.
`timescale 1ns/1ps
`default_nettype none
module operator_panel #(
  parameter int unsigned LAMP_TEST_CYC = panel_pkg::LAMP_TEST_CYC,
  parameter int unsigned LOCK_HOLD_CYC = panel_pkg::LOCK_HOLD_CYC,
  parameter int unsigned BLINK_CYC = panel_pkg::BLINK_CYC,
  parameter int unsigned MSG_CYC = panel_pkg::MSG_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire panel_pkg::keys_t keys,
  input wire panel_pkg::cmd_t remote_cmd,
  input wire panel_pkg::cmd_t serial_cmd,
  input wire panel_pkg::config_t cfg,
  input wire logic [2:0] ext_pset,
  input wire logic [2:0] serial_pset,
  input wire logic ramping,
  input wire logic full_voltage,
  input wire logic [15:0] param_value,
  output panel_pkg::show_t show,
  output logic [9:0] menu,
  output logic [15:0] shown_value,
  output logic value_blank,
  output logic param_write,
  output logic locked,
  output logic start_stop_led,
  output logic running_led,
  output panel_pkg::cmd_t motor_cmd,
  output logic [2:0] active_pset
);
  logic next_p, prev_p;
  logic [15:0] edit_value;
  logic edit_pending, edit_write;
  logic edit_inc, edit_dec, edit_commit;

  // ==========================================================================
  // Key conditioning and editor.
  panel_key_edge u_next (.clk(clk), .rst_n(rst_n), .key(keys.next && !keys.enter), .press(next_p));
  panel_key_edge u_prev (.clk(clk), .rst_n(rst_n), .key(keys.prev), .press(prev_p));

  logic [7:0] keys_q;
  logic [7:0] key_rise;
  assign key_rise = keys & ~keys_q;

  panel_value_edit u_edit (
    .clk(clk),
    .rst_n(rst_n),
    .inc(edit_inc),
    .dec(edit_dec),
    .commit(edit_commit),
    .abandon(next_p || prev_p),
    .stored(param_value),
    .value(edit_value),
    .pending(edit_pending),
    .write(edit_write)
  );

  // ==========================================================================
  // Panel state.
  panel_pkg::show_t show_q, show_d;
  logic [9:0] menu_q, menu_d;
  logic locked_q, locked_d;
  logic combo_done_q, combo_done_d;
  logic [panel_pkg::TIMER_W-1:0] timer_q, timer_d;
  logic [panel_pkg::TIMER_W-1:0] hold_q, hold_d;
  logic [panel_pkg::TIMER_W-1:0] msg_q, msg_d;
  logic [panel_pkg::TIMER_W-1:0] blink_q, blink_d;
  logic blink_on_q, blink_on_d;
  logic [9:0] menu_top;
  logic key_edit_try, key_motor_try;

  assign key_edit_try = key_rise[5] || key_rise[4];
  assign key_motor_try = key_rise[2] || key_rise[1] || key_rise[0];

  always_comb begin
    // Reach of navigation depends on the access settings.
    if (!cfg.extended_access) begin
      menu_top = panel_pkg::MENU_BASIC_LAST;
    end else if (!cfg.all_menus) begin
      menu_top = panel_pkg::MENU_VIEW_LAST;
    end else begin
      menu_top = panel_pkg::MENU_ALL_LAST;
    end
  end

  always_comb begin
    show_d = show_q;
    menu_d = menu_q;
    locked_d = locked_q;
    combo_done_d = combo_done_q;
    timer_d = panel_pkg::tick(timer_q);
    hold_d = hold_q;
    msg_d = panel_pkg::tick(msg_q);
    blink_d = panel_pkg::tick(blink_q);
    blink_on_d = blink_on_q;
    if (blink_q >= panel_pkg::TIMER_W'(BLINK_CYC - 1)) begin
      blink_d = '0;
      blink_on_d = !blink_on_q;
    end
    case (show_q)
      panel_pkg::SHOW_LAMP_TEST: begin
        if (timer_q >= panel_pkg::TIMER_W'(LAMP_TEST_CYC - 1)) begin
          show_d = panel_pkg::SHOW_MENU;
          menu_d = panel_pkg::MENU_FIRST;
        end
      end
      panel_pkg::SHOW_MENU, panel_pkg::SHOW_LOCKED, panel_pkg::SHOW_UNLOCKED: begin
        if (show_q != panel_pkg::SHOW_MENU && msg_q >= panel_pkg::TIMER_W'(MSG_CYC - 1)) begin
          show_d = panel_pkg::SHOW_MENU;
        end
        // Viewing stays allowed while locked.
        if (next_p) begin
          menu_d = (menu_q >= menu_top) ? panel_pkg::MENU_FIRST : menu_q + 10'h001;
        end else if (prev_p) begin
          menu_d = (menu_q <= panel_pkg::MENU_FIRST || menu_q > menu_top) ? menu_top : menu_q - 10'h001;
        end
        // Combination hold; the count restarts when either key is released.
        if (keys.next && keys.enter) begin
          hold_d = panel_pkg::tick(hold_q);
          if (!combo_done_q && hold_q >= panel_pkg::TIMER_W'(LOCK_HOLD_CYC - 1)) begin
            locked_d = !locked_q;
            combo_done_d = 1'b1;
            show_d = locked_q ? panel_pkg::SHOW_UNLOCKED : panel_pkg::SHOW_LOCKED;
            msg_d = '0;
          end
        end else begin
          hold_d = '0;
          combo_done_d = 1'b0;
        end
        if (locked_q && (key_edit_try || key_motor_try)) begin
          show_d = panel_pkg::SHOW_LOCKED;
          msg_d = '0;
        end
      end
      default: begin
        show_d = panel_pkg::SHOW_MENU;
      end
    endcase
  end

  // Editing is rejected while locked or during the lamp test; the lock status menu is read only.
  always_comb begin
    edit_inc = 1'b0;
    edit_dec = 1'b0;
    edit_commit = 1'b0;
    if (!locked_q && show_q != panel_pkg::SHOW_LAMP_TEST && menu_q != panel_pkg::MENU_LOCK_STATUS) begin
      edit_inc = key_rise[5];
      edit_dec = key_rise[4];
      edit_commit = key_rise[3] && !keys.next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      show_q <= panel_pkg::SHOW_LAMP_TEST;
      menu_q <= panel_pkg::MENU_FIRST;
      locked_q <= 1'b0;
      combo_done_q <= 1'b0;
      timer_q <= '0;
      hold_q <= '0;
      msg_q <= '0;
      blink_q <= '0;
      blink_on_q <= 1'b0;
      keys_q <= 8'h00;
    end else begin
      show_q <= show_d;
      menu_q <= menu_d;
      locked_q <= locked_d;
      combo_done_q <= combo_done_d;
      timer_q <= timer_d;
      hold_q <= hold_d;
      msg_q <= msg_d;
      blink_q <= blink_d;
      blink_on_q <= blink_on_d;
      keys_q <= keys;
    end
  end

  // ==========================================================================
  // Command routing by control mode.
  panel_pkg::cmd_t key_cmd, cmd_d, cmd_q;
  logic ss_led_q, ss_led_d, run_led_q, run_led_d, motor_on_q, motor_on_d;
  logic [2:0] pset_q, pset_d;
  logic [2:0] key_pset_q, key_pset_d;

  always_comb begin
    key_cmd = '0;
    if (!locked_q && show_q != panel_pkg::SHOW_LAMP_TEST) begin
      key_cmd.start = key_rise[2] && !motor_on_q;
      key_cmd.stop = key_rise[2] && motor_on_q;
      key_cmd.jog_rev = keys.jog_rev && cfg.jog_rev_enable;
      key_cmd.jog_fwd = keys.jog_fwd && cfg.jog_fwd_enable;
      key_cmd.alarm_reset = key_rise[3] && !keys.next;
    end
    case (cfg.control_mode)
      panel_pkg::MODE_REMOTE: begin
        cmd_d = remote_cmd;
        cmd_d.alarm_reset = remote_cmd.alarm_reset || key_cmd.alarm_reset;
      end
      panel_pkg::MODE_SERIAL: begin
        cmd_d = serial_cmd;
        cmd_d.alarm_reset = serial_cmd.alarm_reset || key_cmd.alarm_reset;
      end
      default: begin
        cmd_d = key_cmd;
      end
    endcase
    // Start wins over a simultaneous stop so the request is not lost.
    motor_on_d = motor_on_q;
    ss_led_d = ss_led_q;
    if (cmd_d.stop) begin
      motor_on_d = 1'b0;
      ss_led_d = 1'b0;
    end
    if (cmd_d.start) begin
      motor_on_d = 1'b1;
      ss_led_d = 1'b1;
    end
    if (ramping) begin
      run_led_d = blink_on_q;
    end else begin
      run_led_d = full_voltage;
    end
    // Internal set chosen from keypad in keyboard or remote mode, from serial link in serial mode.
    key_pset_d = key_pset_q;
    if (cfg.pset_select != panel_pkg::PSET_EXTERNAL && cfg.pset_select <= panel_pkg::PSET_MAX) begin
      key_pset_d = cfg.pset_select;
    end
    if (cfg.control_mode == panel_pkg::MODE_SERIAL && serial_pset != panel_pkg::PSET_EXTERNAL
        && serial_pset <= panel_pkg::PSET_MAX) begin
      key_pset_d = serial_pset;
    end
    if (cfg.pset_select == panel_pkg::PSET_EXTERNAL) begin
      pset_d = ext_pset;
    end else begin
      pset_d = key_pset_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
      motor_on_q <= 1'b0;
      ss_led_q <= 1'b0;
      run_led_q <= 1'b0;
      pset_q <= 3'h1;
      key_pset_q <= 3'h1;
    end else begin
      cmd_q <= cmd_d;
      motor_on_q <= motor_on_d;
      ss_led_q <= ss_led_d;
      run_led_q <= run_led_d;
      pset_q <= pset_d;
      key_pset_q <= key_pset_d;
    end
  end

  // ==========================================================================
  // Display outputs; the lock menu shows 1 for YES and 0 for no.
  logic [15:0] shown_q, shown_d;
  logic blank_q, blank_d;

  always_comb begin
    shown_d = (menu_q == panel_pkg::MENU_LOCK_STATUS) ? {15'h0000, locked_q} : edit_value;
    blank_d = edit_pending && !blink_on_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shown_q <= 16'h0000;
      blank_q <= 1'b0;
    end else begin
      shown_q <= shown_d;
      blank_q <= blank_d;
    end
  end

  assign show = show_q;
  assign menu = menu_q;
  assign shown_value = shown_q;
  assign value_blank = blank_q;
  assign param_write = edit_write;
  assign locked = locked_q;
  assign start_stop_led = ss_led_q;
  assign running_led = run_led_q;
  assign motor_cmd = cmd_q;
  assign active_pset = pset_q;
endmodule // operator_panel
`default_nettype wire

//--- operator_panel_properties.sv
// Concurrent checks on the ports of the operator panel control logic.
`timescale 1ns/1ps
`default_nettype none
module operator_panel_properties #(
  parameter int unsigned LAMP_TEST_CYC = 20,
  parameter int unsigned LOCK_HOLD_CYC = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire panel_pkg::keys_t keys,
  input wire panel_pkg::cmd_t remote_cmd,
  input wire panel_pkg::config_t cfg,
  input wire logic ramping,
  input wire logic full_voltage,
  input wire panel_pkg::show_t show,
  input wire logic [9:0] menu,
  input wire logic param_write,
  input wire logic locked,
  input wire logic start_stop_led,
  input wire logic running_led,
  input wire panel_pkg::cmd_t motor_cmd
);
  localparam int LT_LO = LAMP_TEST_CYC - 2;
  localparam int LT_HI = LAMP_TEST_CYC + 4;
  localparam int LK_LO = LOCK_HOLD_CYC - 2;
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  // ======================================================================
  // Hold length of next plus enter; the slack of two cycles covers the key sampling stages.
  always_comb begin
    hold_d = (keys.next && keys.enter) ? hold_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 8'h00;
    end else begin
      hold_q <= hold_d;
    end
  end
  // ======================================================================
  // Properties.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_lamp_at_reset: assert property ($rose(rst_n) |-> show == panel_pkg::SHOW_LAMP_TEST && menu == 10'h001)
    else $error("lamp test not shown after reset");
  a_lamp_then_menu: assert property ($rose(rst_n) |-> ##[LT_LO:LT_HI] show == panel_pkg::SHOW_MENU)
    else $error("first menu not shown after lamp test");
  a_start_led_on: assert property (motor_cmd.start |-> start_stop_led)
    else $error("start without start/stop LED");
  a_stop_led_off: assert property (motor_cmd.stop && !motor_cmd.start |-> !start_stop_led)
    else $error("stop left start/stop LED lit");
  a_full_voltage_led: assert property ((!ramping && full_voltage) [*3] |-> running_led)
    else $error("running LED not steady at full voltage");
  a_basic_menus_only: assert property ((!cfg.extended_access) [*3] |-> menu >= 10'h001 && menu <= 10'h007)
    else $error("menu outside basic range");
  a_lock_after_hold: assert property ($rose(locked) |-> show == panel_pkg::SHOW_LOCKED && hold_q >= LK_LO)
    else $error("lock without full hold or message");
  a_unlock_message: assert property ($fell(locked) |-> show == panel_pkg::SHOW_UNLOCKED && hold_q >= LK_LO)
    else $error("unlock without full hold or message");
  a_no_locked_write: assert property (param_write |-> !locked)
    else $error("parameter written while locked");
  a_remote_route: assert property (cfg.control_mode == panel_pkg::MODE_REMOTE && remote_cmd.start |=> motor_cmd.start)
    else $error("remote start not routed");
endmodule // operator_panel_properties
bind operator_panel operator_panel_properties #(.LAMP_TEST_CYC(LAMP_TEST_CYC), .LOCK_HOLD_CYC(LOCK_HOLD_CYC))
  i_operator_panel_properties (.clk, .rst_n, .keys, .remote_cmd, .cfg, .ramping, .full_voltage, .show, .menu,
  .param_write, .locked, .start_stop_led, .running_led, .motor_cmd);
`default_nettype wire

//--- panel_keypad_operator.sv
// Model of the operator at the keypad: presses a key pattern and holds it a set number of cycles.
`timescale 1ns/1ps
`default_nettype none
module panel_keypad_operator (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire panel_pkg::keys_t pattern,
  input wire logic [7:0] hold_len,
  output var panel_pkg::keys_t keys,
  output logic busy
);
  logic [7:0] cnt_q;
  // ======================================================================
  // A person lets go of every key between presses, so the keys drop once the hold runs out.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keys <= '0;
      cnt_q <= 8'h00;
    end else if (go && cnt_q == 8'h00) begin
      keys <= pattern;
      cnt_q <= hold_len;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        keys <= '0;
      end
    end
  end
  assign busy = (cnt_q != 8'h00);
endmodule // panel_keypad_operator
`default_nettype wire

//--- tb_operator_panel.sv
// Self-checking testbench of the operator panel control logic.
`timescale 1ns/1ps
`default_nettype none
module tb_operator_panel;
  localparam int LAMP = 20;
  localparam int MSG = 10;
  logic clk, rst_n, go, clr, busy, ramping, full_voltage;
  logic value_blank, param_write, locked, start_stop_led, running_led;
  logic [7:0] hold_len;
  logic [6:0] seen;
  logic [2:0] ext_pset, serial_pset, active_pset;
  logic [9:0] menu;
  logic [15:0] shown_value;
  panel_pkg::keys_t pattern, keys;
  panel_pkg::cmd_t remote_cmd, serial_cmd, motor_cmd;
  panel_pkg::config_t cfg;
  panel_pkg::show_t show;
  int n_mismatch, total_checks, i, k, on;

  operator_panel #(.LAMP_TEST_CYC(LAMP), .LOCK_HOLD_CYC(40), .BLINK_CYC(4), .MSG_CYC(MSG)) i_operator_panel (
    .clk(clk), .rst_n(rst_n), .keys(keys), .remote_cmd(remote_cmd), .serial_cmd(serial_cmd), .cfg(cfg),
    .ext_pset(ext_pset), .serial_pset(serial_pset), .ramping(ramping), .full_voltage(full_voltage),
    .param_value(16'h0010), .show(show), .menu(menu), .shown_value(shown_value), .value_blank(value_blank),
    .param_write(param_write), .locked(locked), .start_stop_led(start_stop_led), .running_led(running_led),
    .motor_cmd(motor_cmd), .active_pset(active_pset));
  panel_keypad_operator i_panel_keypad_operator (.clk(clk), .rst_n(rst_n), .go(go), .pattern(pattern),
    .hold_len(hold_len), .keys(keys), .busy(busy));

  always #4 clk = ~clk;
  // Sticky record of pulses, so a one-cycle output is never missed between checks.
  always @(posedge clk) seen <= clr ? 7'h00 : (seen | {param_write, value_blank, motor_cmd});

  // ======================================================================
  // Tasks.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic press(input panel_pkg::keys_t p, input logic [7:0] n);
    @(posedge clk);
    clr <= 1'b1;
    go <= 1'b1;
    pattern <= p;
    hold_len <= n;
    @(posedge clk);
    clr <= 1'b0;
    go <= 1'b0;
    cyc(2);
    for (k = 0; k < 200 && busy; k++) @(posedge clk);
    if (k == 200) begin
      n_mismatch++;
      end_of_test();
    end
    cyc(4);
  endtask
  task automatic src(input logic [1:0] m, input panel_pkg::cmd_t c);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    if (m == panel_pkg::MODE_REMOTE) remote_cmd <= c;
    else serial_cmd <= c;
    @(posedge clk);
    remote_cmd <= '0;
    serial_cmd <= '0;
    cyc(3);
  endtask

  // ======================================================================
  // Main sequence.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    go = 1'b0;
    clr = 1'b0;
    hold_len = 8'h00;
    pattern = '0;
    remote_cmd = '0;
    serial_cmd = '0;
    ext_pset = 3'h0;
    serial_pset = 3'h0;
    ramping = 1'b0;
    full_voltage = 1'b0;
    cfg = '0;
    cfg.control_mode = panel_pkg::MODE_KEYBOARD;
    cfg.pset_select = 3'h1;
    n_mismatch = 0;
    total_checks = 0;
    cyc(8);
    rst_n <= 1'b1;
    cyc(2);
    chk(show, panel_pkg::SHOW_LAMP_TEST);
    chk(locked, 1'b0);
    cyc(LAMP);
    chk(show, panel_pkg::SHOW_MENU);
    chk(menu, 10'h001);
    note("power up");
    press(8'h20, 8'h02);
    chk(shown_value, 16'h0011);
    cyc(6);
    chk(seen[5], 1'b1);
    press(8'h08, 8'h02);
    chk(seen[6], 1'b1);
    chk(seen[0], 1'b1);
    chk(value_blank, 1'b0);
    note("edit");
    for (i = 0; i < 7; i++) begin
      press(8'h80, 8'h02);
      chk(menu, 16'((i + 1) % 7 + 1));
    end
    press(8'h40, 8'h02);
    chk(menu, 10'h007);
    @(posedge clk) cfg.extended_access <= 1'b1;
    press(8'h80, 8'h02);
    chk(menu, 10'h008);
    note("navigation");
    press(8'h04, 8'h02);
    chk(seen[4], 1'b1);
    chk(start_stop_led, 1'b1);
    chk(menu, 10'h008);
    press(8'h04, 8'h02);
    chk(seen[3], 1'b1);
    chk(start_stop_led, 1'b0);
    for (i = 0; i < 2; i++) begin
      press(8'(1 << i), 8'h03);
      chk(seen[1 + i], 1'b0);
      @(posedge clk) cfg[i] <= 1'b1;
      press(8'(1 << i), 8'h03);
      chk(seen[1 + i], 1'b1);
    end
    note("motor keys");
    @(posedge clk) ramping <= 1'b1;
    on = 0;
    for (k = 0; k < 12; k++) begin
      @(posedge clk);
      on += (running_led === 1'b1) ? 1 : 0;
    end
    chk(on > 0 && on < 12, 1'b1);
    @(posedge clk) ramping <= 1'b0;
    full_voltage <= 1'b1;
    cyc(4);
    chk(running_led, 1'b1);
    note("running indicator");
    press(8'h88, 8'd30);
    chk(locked, 1'b0);
    press(8'h88, 8'd42);
    chk(locked, 1'b1);
    chk(show, panel_pkg::SHOW_LOCKED);
    chk(menu, 10'h008);
    cyc(MSG + 2);
    press(8'h20, 8'h02);
    chk(show, panel_pkg::SHOW_LOCKED);
    press(8'h04, 8'h02);
    chk(seen[4], 1'b0);
    press(8'h80, 8'h02);
    chk(menu, 10'h009);
    // From menu 9 down to 1, wrap to the viewing top, then down to the lock status menu.
    for (i = 0; i < 43; i++) press(8'h40, 8'h02);
    chk(menu, 10'h0DD);
    chk(shown_value, 16'h0001);
    cyc(MSG + 2);
    press(8'h88, 8'd42);
    chk(locked, 1'b0);
    chk(show, panel_pkg::SHOW_UNLOCKED);
    chk(shown_value, 16'h0000);
    press(8'h20, 8'h02);
    cyc(6);
    chk(seen[5], 1'b0);
    chk(shown_value, 16'h0000);
    note("keypad lock");
    for (i = 2; i < 4; i++) begin
      @(posedge clk) cfg.control_mode <= 2'(i);
      press(8'h04, 8'h02);
      chk(seen[4], 1'b0);
      press(8'h08, 8'h02);
      chk(seen[0], 1'b1);
      src(2'(i), 5'h10);
      chk(seen[4], 1'b1);
      chk(start_stop_led, 1'b1);
      src(2'(i), 5'h08);
      chk(start_stop_led, 1'b0);
    end
    note("control modes");
    @(posedge clk) cfg.control_mode <= panel_pkg::MODE_KEYBOARD;
    cfg.pset_select <= 3'h0;
    ext_pset <= 3'h3;
    cyc(4);
    chk(active_pset, 3'h3);
    @(posedge clk) cfg.pset_select <= 3'h4;
    cyc(4);
    chk(active_pset, 3'h4);
    @(posedge clk) cfg.control_mode <= panel_pkg::MODE_SERIAL;
    serial_pset <= 3'h2;
    cyc(4);
    chk(active_pset, 3'h2);
    note("parameter set");
    end_of_test();
  end
endmodule // tb_operator_panel
`default_nettype wire
